// ==== common/scpc_regs.svh ====
`ifndef SCPC_REGS_SVH
`define SCPC_REGS_SVH

// Register indices as carried in the instruction byte
`define SCPC_CORE_CFG_ADDR 5'h00
`define SCPC_IFACE_CFG_ADDR 5'h01

// Reset values
`define SCPC_CORE_CFG_RST 32'h0000_0000
`define SCPC_IFACE_CFG_RST 32'h0000_0800

// Field positions in core_config_word_one
`define SCPC_LSB_FIRST_BIT 0
`define SCPC_INPUT_ONLY_BIT 1

// Field positions in interface_config_word_two
`define SCPC_INT_COMMIT_BIT 23

// Instruction byte layout
`define SCPC_INSTR_READ_BIT 7
`define SCPC_INSTR_ADDR_MSB 4

// Timing
`define SCPC_CLK_PERIOD_NS 50
`define SCPC_SYNC_DIV 4
`define SCPC_SYNC_TICK_PHASE 2'h1
`define SCPC_COMMIT_SYNC_PERIODS 2
`define SCPC_COMMIT_PULSE_CYCLES (`SCPC_SYNC_DIV * `SCPC_COMMIT_SYNC_PERIODS)

`endif

// ==== common/scpc_pkg.sv ====
package scpc_pkg;

    typedef enum logic [0:0] {
        PH_INSTR,
        PH_DATA
    } scpc_phase_type;

    typedef struct packed {
        logic [1:0] div;
        logic sclk_q;
        logic [2:0] commit_sync;
        logic [2:0] key_meta;
        logic [2:0] key_sync;
        logic [2:0] key_prev;
        logic [3:0] pulse_cnt;
        scpc_phase_type phase;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic rd;
        logic [4:0] addr;
        logic [31:0] rd_shift;
        logic dout;
        logic [31:0] buf_core;
        logic [31:0] buf_iface;
        logic [31:0] act_core;
        logic [31:0] act_iface;
    } scpc_state_type;

endpackage

// ==== hw/scpc_top.sv ====
`timescale 1ns/1ns
`include "scpc_regs.svh"

// What this block does
// - Serial clock edges shift data and advance the serial state machine.
// - Chip select high releases both data outputs.
// - Chip select high freezes a transfer; it resumes when select returns low.
// - Core word bit 1 makes the data pin input only; clear means bidirectional.
// - Separate output only drives in two-line mode and carries read data.
// - Abort ends the transfer and resyncs the port, registers untouched.
// - After abort the next byte is an instruction byte.
// - Writes land in the buffer; a commit rising edge copies to active.
// - Commit pin is an input, an output when internal commit is enabled.
// - Core word bit 0 selects LSB-first for every byte, instruction included.
// - Highest register bit index is its most significant bit.
// - Sync clock is the system clock divided by four, driven out.
// - Commit sampled on sync clock, latency fixed when setup is met.
// - Any change on the keying-select pins also commits the buffer.
// - Instruction: bit 7 read, bits 6 and 5 ignored, bits 4 to 0 address.
// - Write bits taken on rising edges; read bits driven on falling edges.
// - Abort keeps completed buffer bytes and drops a partial byte.
module scpc_top
    import scpc_pkg::*;
(
    input wire logic clk_i, // System clock, 20 MHz
    input wire logic reset_n_i, // Asynchronous reset, active low
    input wire logic sclk_i, // Serial clock from host
    input wire logic cs_n_i, // Chip select, active low
    input wire logic sdio_i, // Data pin, input side
    output logic sdio_o, // Data pin, output side
    output logic sdio_oe_o, // Data pin drive enable
    output logic serial_data_output_o, // Separate read data pin
    output logic serial_data_output_oe_o, // Separate read data pin enable
    input wire logic io_abort_i, // Transfer abort, active high
    input wire logic commit_i, // Commit pin, input side
    output logic commit_o, // Commit pin, output side
    output logic commit_oe_o, // Commit pin drive enable
    input wire logic [2:0] keying_sel_i, // Keying-select pins
    output logic sync_clk_o, // System clock divided by four
    output logic [31:0] core_config_word_one_o, // Active core word
    output logic [31:0] interface_config_word_two_o // Active interface word
);

    scpc_state_type st_r;
    scpc_state_type st_nxt;

    logic sclk_rise;
    logic sclk_fall;
    logic sync_tick;
    logic lsb_first;
    logic input_only;
    logic int_commit;
    logic pulse_active;
    logic commit_src;
    logic commit_edge;
    logic key_edge;
    logic copy;
    logic reading;

    function automatic logic [31:0] put_byte(
        input logic [31:0] word,
        input logic [1:0] idx,
        input logic [7:0] b
    );
        logic [31:0] w;
        w = word;
        w[idx * 8 +: 8] = b;
        return w;
    endfunction

    function automatic logic [31:0] read_word(
        input logic [4:0] addr,
        input logic [31:0] core,
        input logic [31:0] iface
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        if (addr == `SCPC_CORE_CFG_ADDR) begin
            w = core;
        end else if (addr == `SCPC_IFACE_CFG_ADDR) begin
            w = iface;
        end
        return w;
    endfunction

    // Serial clock is sampled like any other pin; at 20 MHz it must stay well below 10 MHz
    assign sclk_rise = sclk_i & ~st_r.sclk_q;
    assign sclk_fall = ~sclk_i & st_r.sclk_q;
    assign sync_tick = (st_r.div == `SCPC_SYNC_TICK_PHASE);
    assign lsb_first = st_r.act_core[`SCPC_LSB_FIRST_BIT];
    assign input_only = st_r.act_core[`SCPC_INPUT_ONLY_BIT];
    assign int_commit = st_r.act_iface[`SCPC_INT_COMMIT_BIT];
    assign pulse_active = (st_r.pulse_cnt != 4'h0);
    // Own pulse feeds the commit path directly so pin loading cannot distort it
    assign commit_src = int_commit ? pulse_active : commit_i;
    assign commit_edge = sync_tick & st_r.commit_sync[1] & ~st_r.commit_sync[2];
    assign key_edge = sync_tick & (st_r.key_sync != st_r.key_prev);
    assign copy = commit_edge | key_edge;
    assign reading = (st_r.phase == PH_DATA) & st_r.rd & ~cs_n_i & ~io_abort_i;

    always_comb begin
        logic [7:0] sh;
        logic [1:0] idx;
        sh = 8'h00;
        idx = 2'h0;
        st_nxt = st_r;
        st_nxt.div = st_r.div + 2'h1;
        st_nxt.sclk_q = sclk_i;
        if (st_r.pulse_cnt != 4'h0) begin
            st_nxt.pulse_cnt = st_r.pulse_cnt - 4'h1;
        end
        // Sampling on the sync tick gives fixed latency for strobes that meet setup
        if (sync_tick) begin
            st_nxt.commit_sync = {st_r.commit_sync[1:0], commit_src};
            st_nxt.key_meta = keying_sel_i;
            st_nxt.key_sync = st_r.key_meta;
            st_nxt.key_prev = st_r.key_sync;
        end
        if (copy) begin
            st_nxt.act_core = st_r.buf_core;
            st_nxt.act_iface = st_r.buf_iface;
        end
        if (io_abort_i) begin
            st_nxt.phase = PH_INSTR;
            st_nxt.bit_cnt = 3'h0;
            st_nxt.byte_cnt = 2'h0;
            st_nxt.shift = 8'h00;
        end else if (!cs_n_i) begin
            if (sclk_rise) begin
                if (lsb_first) begin
                    sh = {sdio_i, st_r.shift[7:1]};
                end else begin
                    sh = {st_r.shift[6:0], sdio_i};
                end
                st_nxt.shift = sh;
                st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
                if (st_r.bit_cnt == 3'h7) begin
                    if (st_r.phase == PH_INSTR) begin
                        st_nxt.rd = sh[`SCPC_INSTR_READ_BIT];
                        st_nxt.addr = sh[`SCPC_INSTR_ADDR_MSB:0];
                        st_nxt.phase = PH_DATA;
                        st_nxt.byte_cnt = 2'h0;
                        st_nxt.rd_shift = read_word(sh[`SCPC_INSTR_ADDR_MSB:0],
                            st_r.act_core, st_r.act_iface);
                    end else begin
                        // First byte on the wire is the top byte unless LSB first
                        idx = lsb_first ? st_r.byte_cnt : ~st_r.byte_cnt;
                        if (!st_r.rd && st_r.addr == `SCPC_CORE_CFG_ADDR) begin
                            st_nxt.buf_core = put_byte(st_r.buf_core, idx, sh);
                        end
                        if (!st_r.rd && st_r.addr == `SCPC_IFACE_CFG_ADDR) begin
                            st_nxt.buf_iface = put_byte(st_r.buf_iface, idx, sh);
                        end
                        st_nxt.byte_cnt = st_r.byte_cnt + 2'h1;
                        if (st_r.byte_cnt == 2'h3) begin
                            st_nxt.phase = PH_INSTR;
                            if (!st_r.rd && int_commit) begin
                                st_nxt.pulse_cnt = 4'(`SCPC_COMMIT_PULSE_CYCLES);
                            end
                        end
                    end
                end
            end
            if (sclk_fall && st_r.phase == PH_DATA && st_r.rd) begin
                if (lsb_first) begin
                    st_nxt.dout = st_r.rd_shift[0];
                    st_nxt.rd_shift = {1'b0, st_r.rd_shift[31:1]};
                end else begin
                    st_nxt.dout = st_r.rd_shift[31];
                    st_nxt.rd_shift = {st_r.rd_shift[30:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
            st_r.phase <= PH_INSTR;
            st_r.buf_core <= `SCPC_CORE_CFG_RST;
            st_r.buf_iface <= `SCPC_IFACE_CFG_RST;
            st_r.act_core <= `SCPC_CORE_CFG_RST;
            st_r.act_iface <= `SCPC_IFACE_CFG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sdio_o = st_r.dout;
    assign sdio_oe_o = reading & ~input_only;
    assign serial_data_output_o = st_r.dout;
    assign serial_data_output_oe_o = reading & input_only;
    assign commit_o = pulse_active;
    assign commit_oe_o = int_commit;
    assign sync_clk_o = st_r.div[1];
    assign core_config_word_one_o = st_r.act_core;
    assign interface_config_word_two_o = st_r.act_iface;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_sync_period;
        sync_clk_o ##1 !sync_clk_o [*2] ##1 sync_clk_o;
    endsequence

    sequence s_commit_pulse;
        commit_o [*8] ##1 !commit_o;
    endsequence

    a_hiz_when_deselected: assert property (
        cs_n_i |-> !sdio_oe_o && !serial_data_output_oe_o)
        else $error("data outputs driven while deselected");

    a_single_pin_sdo: assert property (
        !input_only |-> !serial_data_output_oe_o)
        else $error("separate output driven in single pin mode");

    a_abort_restart: assert property (
        io_abort_i |=> st_r.phase == PH_INSTR && st_r.bit_cnt == 3'h0)
        else $error("abort did not restart at instruction byte");

    a_abort_keeps_buf: assert property (
        io_abort_i |=> st_r.buf_core == $past(st_r.buf_core)
            && st_r.buf_iface == $past(st_r.buf_iface))
        else $error("abort altered the buffer");

    a_cs_suspend: assert property (
        cs_n_i && !io_abort_i |=> $stable(st_r.bit_cnt) && $stable(st_r.byte_cnt)
            && $stable(st_r.phase))
        else $error("transfer advanced while deselected");

    a_sync_div_four: assert property (
        $rose(sync_clk_o) |=> s_sync_period)
        else $error("sync clock is not divide by four");

    a_commit_copies: assert property (
        copy |=> st_r.act_core == $past(st_r.buf_core)
            && st_r.act_iface == $past(st_r.buf_iface))
        else $error("commit did not copy buffer");

    a_no_copy_idle: assert property (
        !copy |=> $stable(st_r.act_core) && $stable(st_r.act_iface))
        else $error("active words changed without commit");

    a_internal_pulse: assert property (
        $rose(commit_o) |-> s_commit_pulse)
        else $error("internal commit pulse width wrong");

    a_one_copy_strobe: assert property (
        commit_edge |=> !commit_edge [*4])
        else $error("commit edge seen twice for one strobe");

    a_key_change_copy: assert property (
        $changed(keying_sel_i) |-> ##[1:12] copy)
        else $error("keying change did not commit");

endmodule

// ==== dv/scpc_host.sv ====
`timescale 1ns/1ns
module scpc_host (
    input wire logic clk_i, // System clock
    output logic sclk_o, // Serial clock, low between transfers; falls and rises once while deselected before bit ho
    output logic cs_n_o, // Chip select, active low
    output logic sdio_o, // Host data bit
    output logic sdio_oe_o, // Host drives the data pin
    input wire logic sdio_i, // Resolved data pin
    input wire logic sdo_i // Resolved separate data pin
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdio_o = 1'b0;
        sdio_oe_o = 1'b0;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Stops after nb bits so an abort can follow; deselects before bit ho
    // With keep set, select stays low after the frame
    task automatic xfer(input logic [7:0] ins, input logic [31:0] wd, input bit lsb,
                        input bit two, input int nb, input int ho, input bit keep,
                        output logic [31:0] rd);
        logic [39:0] f;
        int k;
        f = {ins, wd};
        rd = 32'h0;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            if (i == ho) begin
                cs_n_o <= 1'b1;
                tk(3);
                sclk_o <= 1'b0;
                tk(3);
                sclk_o <= 1'b1;
                tk(3);
                cs_n_o <= 1'b0;
            end
            k = lsb ? ((i < 8) ? 32 + i : i - 8) : 39 - i;
            sclk_o <= 1'b0;
            sdio_oe_o <= !(ins[7] && i >= 8);
            sdio_o <= f[k];
            tk(3);
            @(negedge clk_i);
            if (i >= 8) rd[k] = two ? sdo_i : sdio_i;
            @(posedge clk_i);
            sclk_o <= 1'b1;
            tk(1);
            // Let go of the pin on the same clock edge that the device turns it round
            if (i == 7 && ins[7]) sdio_oe_o <= 1'b0;
            tk(2);
        end
        sclk_o <= 1'b0;
        tk(3);
        if (!keep) begin
            cs_n_o <= 1'b1;
        end
        sdio_oe_o <= 1'b0;
    endtask
endmodule

// ==== dv/serial_config_port_commit_bench.sv ====
`timescale 1ns/1ns
`include "scpc_regs.svh"
module serial_config_port_commit_bench;
    logic clk = 1'b0, reset_n = 1'b0, abort = 1'b0, cmt = 1'b0;
    logic [2:0] key = 3'h0;
    logic sclk, cs_n, h_d, h_oe, d_o, d_oe, s_o, s_oe, c_o, c_oe, sync;
    logic [31:0] core, iface, rd, seed = 32'h24d0af32;
    logic [31:0] bm [2];
    logic [31:0] am [2];
    int fails = 0, n_checks = 0;
    time t_last = 0;
    bit keep_cs = 1'b0;
    // An undriven line shows the inverse of the host bit on sdio_w, of the device bit on sdo_w
    wire sdio_w = d_oe ? d_o : (h_oe ? h_d : !h_d);
    wire sdo_w = s_oe ? s_o : !s_o;
    initial begin
        forever #25 clk = !clk;
    end
    scpc_top u_dut (
        .clk_i(clk),
        .reset_n_i(reset_n),
        .sclk_i(sclk),
        .cs_n_i(cs_n),
        .sdio_i(sdio_w),
        .sdio_o(d_o),
        .sdio_oe_o(d_oe),
        .serial_data_output_o(s_o),
        .serial_data_output_oe_o(s_oe),
        .io_abort_i(abort),
        .commit_i(c_oe ? c_o : cmt),
        .commit_o(c_o),
        .commit_oe_o(c_oe),
        .keying_sel_i(key),
        .sync_clk_o(sync),
        .core_config_word_one_o(core),
        .interface_config_word_two_o(iface)
    );
    scpc_host u_host (.clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(h_d),
        .sdio_oe_o(h_oe), .sdio_i(sdio_w), .sdo_i(sdo_w));
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic xf(input logic [7:0] ins, input logic [31:0] d, input int nb, input int ho);
        u_host.xfer(ins, d, am[0][0], am[0][1], nb, ho, keep_cs, rd);
        if (!ins[7] && nb == 40 && ins[4:0] < 2) bm[ins[0]] = d;
        // Internal commit, when enabled, follows every completed write
        if (!ins[7] && nb == 40 && am[1][23]) begin
            tk(30);
            am = bm;
        end
    endtask
    task automatic rdc(input logic [4:0] a, input logic [1:0] x);
        xf({1'b1, x, a}, 32'h0, 40, -1);
        chk("read data", (a < 2) ? am[a[0]] : 32'h0, rd);
    endtask
    task automatic rall;
        for (int a = 0; a < 3; a++) rdc((a == 2) ? 5'h05 : a[4:0], a[1:0] + 2'h1);
    endtask
    task automatic upd;
        cmt <= 1'b1;
        tk(`SCPC_COMMIT_PULSE_CYCLES);
        cmt <= 1'b0;
        tk(20);
        am = bm;
    endtask
    task automatic act;
        chk("core word", am[0], core);
        chk("iface word", am[1], iface);
    endtask
    always @(posedge sync) begin
        if (t_last != 0) chk("sync period", 32'hc8, 32'($time - t_last));
        t_last = $time;
    end
    always @(negedge clk) begin
        if (reset_n && ((cs_n && (d_oe || s_oe)) || (am[0][1] ? d_oe : s_oe))) begin
            fails++;
            $display("BAD data pin drive expected 0 seen 1");
        end
    end
    initial begin
        #3_000_000;
        fails++;
        end_sim();
    end
    initial begin
        am[0] = `SCPC_CORE_CFG_RST;
        am[1] = `SCPC_IFACE_CFG_RST;
        bm = am;
        tk(5);
        reset_n <= 1'b1;
        tk(2);
        act();
        for (int a = 0; a < 3; a++) begin
            seed = nx(seed);
            xf({3'h0, (a == 2) ? 5'h05 : a[4:0]}, seed & 32'hff7f_fffc, 40, -1);
        end
        act();
        rall();
        upd();
        act();
        rall();
        seed = nx(seed);
        xf(8'h01, seed, 19, -1);
        abort <= 1'b1;
        tk(3);
        abort <= 1'b0;
        bm[1][31:24] = seed[31:24];
        act();
        xf(8'h00, seed & 32'hff7f_fffc, 40, 20);
        upd();
        act();
        for (int j = 1; j < 4; j++) begin
            seed = nx(seed);
            xf(8'h01, seed & 32'hff7f_ffff, 40, -1);
            key <= key ^ j[2:0];
            tk(20);
            am = bm;
            act();
        end
        xf(8'h00, 32'h0000_0001, 40, -1);
        upd();
        seed = nx(seed);
        xf(8'h01, seed & 32'hff7f_ffff, 40, -1);
        rall();
        upd();
        act();
        xf(8'h00, 32'h0000_0003, 40, -1);
        upd();
        rall();
        seed = nx(seed);
        xf(8'h01, seed | 32'h0080_0000, 40, -1);
        upd();
        chk("commit oe", {31'h0, am[1][23]}, {31'h0, c_oe});
        seed = nx(seed);
        xf(8'h01, seed | 32'h0080_0000, 40, -1);
        act();
        keep_cs = 1'b1;
        seed = nx(seed);
        xf(8'h01, seed | 32'h0080_0000, 40, -1);
        rall();
        keep_cs = 1'b0;
        act();
        end_sim();
    end
endmodule
